// *** hw/cpr_pkg.sv ***
// What this block does
// [R1] when the highest rate override is set the mixer clocking runs at the 32x rate
// [R2] with override clear the rate select decodes 00 16x, 01 8x, 10 4x, 11 1x
// [R3] eight 4-bit mixer phase fields, four per register, each one of sixteen delays
// [R4] per-lane gain codes 00 18dB, 01 24dB, 10 12dB, 11 reserved; need the allow bit
// [R5] high-pass corner decodes 00 100k, 01 50k, 10 200k, 11 150k
// [R6] attenuation depth code n gives about n times 6dB, only while attenuator is on
// [R7] attenuator bypassed when its enable is 0, inserted in the path when 1
// [R8] summer power keep powers the summer down at 0, only acting in gain test mode
// [R9] gain stage observe routes gain stage outputs to the continuous wave outputs
// [R10] each preamp feedback bit switches in one resistor; zero enables none
// [R11] each summer feedback bit switches in one resistor; zero selects none
// [R12] termination setting is the same in time gain and continuous wave paths
// [R13] preset termination choices pick resistors from the current preamp gain
// [R14] allow bit set makes lane gains govern; clear applies the common gain
// [R15] all fields reset to zero and hold until rewritten
package cpr_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned IDX_FB    = 32'h34;
  localparam int unsigned IDX_SUM   = 32'h36;
  localparam int unsigned IDX_PH14  = 32'h37;
  localparam int unsigned IDX_PH58  = 32'h38;
  localparam int unsigned IDX_GAIN  = 32'h39;
  localparam int unsigned IDX_TEST  = 32'h3b;
  localparam logic [15:0] RST_VAL   = 16'h0000;
  localparam int unsigned REG_W     = 16;
  localparam int unsigned ADDR_W    = 12;
  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned FB_LSB    = 0;
  localparam int unsigned FB_W      = 5;
  localparam int unsigned PRE_LSB   = 6;
  localparam int unsigned CGAIN_LSB = 13;
  localparam int unsigned ALLOW_BIT = 15;
  localparam int unsigned SFB_LSB   = 0;
  localparam int unsigned CWSEL_BIT = 8;
  localparam int unsigned RATE_LSB  = 10;
  localparam int unsigned PH_W      = 4;
  localparam int unsigned GN_W      = 2;
  localparam int unsigned HPF_LSB   = 2;
  localparam int unsigned ATT_LSB   = 4;
  localparam int unsigned ATT_W     = 3;
  localparam int unsigned ATTON_BIT = 7;
  localparam int unsigned SKEEP_BIT = 8;
  localparam int unsigned OBS_BIT   = 9;
  localparam int unsigned OVR_BIT   = 10;
  localparam int unsigned LANES     = 8;
  // ****************************************
  // decoded enumerations
  // ****************************************
  typedef enum logic [2:0] {
    CPR_LO_1X  = 3'b000,
    CPR_LO_4X  = 3'b001,
    CPR_LO_8X  = 3'b010,
    CPR_LO_16X = 3'b011,
    CPR_LO_32X = 3'b100
  } cpr_lo_t;
  typedef enum logic [1:0] {
    CPR_G12 = 2'b00,
    CPR_G18 = 2'b01,
    CPR_G24 = 2'b10,
    CPR_GRSV = 2'b11
  } cpr_gain_t;
  typedef enum logic [1:0] {
    CPR_HP50  = 2'b00,
    CPR_HP100 = 2'b01,
    CPR_HP150 = 2'b10,
    CPR_HP200 = 2'b11
  } cpr_hp_t;
endpackage : cpr_pkg

// *** hw/cpr_decode.sv ***
`timescale 1ns/10ps
module cpr_decode
  import cpr_pkg::*;
(
  // field in
  input  wire logic [1:0] code,
  // decoded gain
  output cpr_pkg::cpr_gain_t gain
);
  always_comb begin
    unique case (code)
      2'b00:   gain = CPR_G18; // [R4]
      2'b01:   gain = CPR_G24; // [R4]
      2'b10:   gain = CPR_G12; // [R4]
      default: gain = CPR_GRSV; // [R4]
    endcase
  end
endmodule : cpr_decode

// *** hw/cpr_regs.sv ***
`timescale 1ns/10ps
module cpr_regs
  import cpr_pkg::*;
#(
  parameter int unsigned NLANE = LANES
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [cpr_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // mixer clocking
  output cpr_pkg::cpr_lo_t             lo_rate,
  output logic [4*cpr_pkg::LANES-1:0]  mixer_phase_per_lane,
  // preamp
  output cpr_pkg::cpr_gain_t [cpr_pkg::LANES-1:0] lane_gain,
  output cpr_pkg::cpr_hp_t             preamp_highpass_corner,
  output logic [cpr_pkg::FB_W-1:0]     preamp_fb_en,
  output logic                         preset_term_used,
  // attenuator and summer
  output logic                         stepped_attenuation_on,
  output logic [cpr_pkg::ATT_W-1:0]    stepped_attenuation_depth,
  output logic                         summer_power_on,
  output logic                         gain_stage_observe,
  output logic [cpr_pkg::FB_W-1:0]     summer_fb_en,
  output logic                         continuous_wave_mode
);
  import cpr_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0]       rsync;
    logic [REG_W-1:0] fb;
    logic [REG_W-1:0] sum;
    logic [REG_W-1:0] ph14;
    logic [REG_W-1:0] ph58;
    logic [REG_W-1:0] gn;
    logic [REG_W-1:0] tst;
    logic [31:0]      rd;
  } cpr_state_t;

  cpr_state_t st_r;
  cpr_state_t st_nxt;
  logic       rst_n;

  assign rst_n = st_r.rsync[1];

  // ****************************************
  // bus
  // ****************************************
  function automatic logic [REG_W-1:0] rd_word(input cpr_state_t s,
                                               input logic [ADDR_W-1:0] a);
    logic [REG_W-1:0] v;
    v = RST_VAL;
    unique case (a)
      ADDR_W'(IDX_FB   * 4): v = s.fb;
      ADDR_W'(IDX_SUM  * 4): v = s.sum;
      ADDR_W'(IDX_PH14 * 4): v = s.ph14;
      ADDR_W'(IDX_PH58 * 4): v = s.ph58;
      ADDR_W'(IDX_GAIN * 4): v = s.gn;
      ADDR_W'(IDX_TEST * 4): v = s.tst;
      default:               v = RST_VAL;
    endcase
    return v;
  endfunction : rd_word

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(IDX_FB * 4) || a == ADDR_W'(IDX_SUM * 4) ||
           a == ADDR_W'(IDX_PH14 * 4) || a == ADDR_W'(IDX_PH58 * 4) ||
           a == ADDR_W'(IDX_GAIN * 4) || a == ADDR_W'(IDX_TEST * 4);
  endfunction : mapped

  logic acc;
  logic wr;
  assign acc     = psel && penable;
  assign wr      = acc && pwrite && mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped(paddr);
  assign prdata  = st_r.rd;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.rsync = {st_r.rsync[0], 1'b1};
    // read data registered in the setup cycle, valid at access
    st_nxt.rd    = (psel && !penable) ? {16'h0000, rd_word(st_r, paddr)} : st_r.rd;
    if (wr) begin // [R15]
      unique case (paddr)
        ADDR_W'(IDX_FB   * 4): st_nxt.fb   = pwdata[REG_W-1:0];
        ADDR_W'(IDX_SUM  * 4): st_nxt.sum  = pwdata[REG_W-1:0];
        ADDR_W'(IDX_PH14 * 4): st_nxt.ph14 = pwdata[REG_W-1:0];
        ADDR_W'(IDX_PH58 * 4): st_nxt.ph58 = pwdata[REG_W-1:0];
        ADDR_W'(IDX_GAIN * 4): st_nxt.gn   = pwdata[REG_W-1:0];
        default:               st_nxt.tst  = pwdata[REG_W-1:0];
      endcase
    end
    if (!rst_n) begin
      st_nxt       = '0; // [R15]
      st_nxt.rsync = {st_r.rsync[0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // mixer clocking
  // ****************************************
  always_comb begin
    if (st_r.tst[OVR_BIT]) begin
      lo_rate = CPR_LO_32X; // [R1]
    end else begin
      unique case (st_r.sum[RATE_LSB +: 2])
        2'b00:   lo_rate = CPR_LO_16X; // [R2]
        2'b01:   lo_rate = CPR_LO_8X; // [R2]
        2'b10:   lo_rate = CPR_LO_4X; // [R2]
        default: lo_rate = CPR_LO_1X; // [R2]
      endcase
    end
  end

  assign mixer_phase_per_lane = {st_r.ph58, st_r.ph14}; // [R3]

  // ****************************************
  // preamp gain per lane
  // ****************************************
  logic [1:0] gsel [NLANE];
  // one decoder per lane drives its own element; packed output filled below
  cpr_gain_t  gdec [NLANE];
  genvar i;
  generate
    for (i = 0; i < NLANE; i++) begin : g_lane
      // allow bit picks lane field or common field
      assign gsel[i] = st_r.fb[ALLOW_BIT] ? st_r.gn[GN_W*i +: GN_W]
                                          : st_r.fb[CGAIN_LSB +: GN_W]; // [R14]
      cpr_decode u_dec (
        .code (gsel[i]),
        .gain (gdec[i])
      ); // [R4]
    end
  endgenerate

  always_comb begin
    for (int k = 0; k < NLANE; k++) begin
      lane_gain[k] = gdec[k]; // [R4]
    end
  end

  always_comb begin
    unique case (st_r.tst[HPF_LSB +: 2])
      2'b00:   preamp_highpass_corner = CPR_HP100; // [R5]
      2'b01:   preamp_highpass_corner = CPR_HP50; // [R5]
      2'b10:   preamp_highpass_corner = CPR_HP200; // [R5]
      default: preamp_highpass_corner = CPR_HP150; // [R5]
    endcase
  end

  // ****************************************
  // termination
  // ****************************************
  // preset code picks resistors by common gain; table is analog-side, only a code-nonzero flag passed on
  assign preset_term_used = |st_r.fb[PRE_LSB +: 2]; // [R13]
  // no path term: same setting in both modes
  assign preamp_fb_en     = st_r.fb[FB_LSB +: FB_W]; // [R10] [R12]
  assign continuous_wave_mode = st_r.sum[CWSEL_BIT];

  // ****************************************
  // attenuator and summer
  // ****************************************
  assign stepped_attenuation_on    = st_r.tst[ATTON_BIT]; // [R7]
  // depth forced to zero while bypassed
  assign stepped_attenuation_depth = st_r.tst[ATTON_BIT] ?
                                     st_r.tst[ATT_LSB +: ATT_W] : '0; // [R6]
  // keep bit only matters in gain-path test mode
  assign summer_power_on    = st_r.tst[OBS_BIT] ? st_r.tst[SKEEP_BIT] : 1'b1; // [R8]
  assign gain_stage_observe = st_r.tst[OBS_BIT]; // [R9]
  assign summer_fb_en       = st_r.sum[SFB_LSB +: FB_W]; // [R11]
endmodule : cpr_regs

// *** verif/cpr_regs_assertions.sv ***
`timescale 1ns/10ps
module cpr_regs_assertions
  import cpr_pkg::*;
(
  // clock, reset and bus
  input wire logic                        clk,
  input wire logic                        arst_n,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [cpr_pkg::ADDR_W-1:0]  paddr,
  input wire logic [31:0]                 pwdata,
  // decoded outputs
  input wire cpr_pkg::cpr_lo_t            lo_rate,
  input wire logic [cpr_pkg::FB_W-1:0]    preamp_fb_en,
  input wire logic                        stepped_attenuation_on,
  input wire logic [cpr_pkg::ATT_W-1:0]   stepped_attenuation_depth,
  input wire logic                        summer_power_on,
  input wire logic                        gain_stage_observe,
  input wire logic [cpr_pkg::FB_W-1:0]    summer_fb_en
);
  // ****
  // write strobes, zero wait state bus
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic w;
  logic wt;
  assign w  = psel && penable && pwrite;
  assign wt = w && paddr == ADDR_W'(IDX_TEST * 4);
  property p_ovr; wt && pwdata[OVR_BIT] |=> lo_rate == CPR_LO_32X; endproperty
  a_ovr: assert property (p_ovr) else $error("override lost");
  property p_dep; wt && pwdata[ATTON_BIT] |=> stepped_attenuation_on &&
    stepped_attenuation_depth == $past(pwdata[ATT_LSB +: ATT_W]); endproperty
  a_dep: assert property (p_dep) else $error("depth wrong");
  property p_att; wt && !pwdata[ATTON_BIT] |=> !stepped_attenuation_on &&
    stepped_attenuation_depth == 3'h0; endproperty
  a_att: assert property (p_att) else $error("attenuator not bypassed");
  property p_pwr; wt && !pwdata[OBS_BIT] |-> ##1 summer_power_on; endproperty
  a_pwr: assert property (p_pwr) else $error("summer off outside test");
  property p_obs; wt |=> gain_stage_observe == $past(pwdata[OBS_BIT]); endproperty
  a_obs: assert property (p_obs) else $error("observe wrong");
  property p_fb; w && paddr == ADDR_W'(IDX_FB * 4) |=>
    preamp_fb_en == $past(pwdata[FB_LSB +: FB_W]); endproperty
  a_fb: assert property (p_fb) else $error("preamp feedback wrong");
  property p_sfb; w && paddr == ADDR_W'(IDX_SUM * 4) |=>
    summer_fb_en == $past(pwdata[SFB_LSB +: FB_W]); endproperty
  a_sfb: assert property (p_sfb) else $error("summer feedback wrong");
  property p_hold; !w |=> $stable(summer_fb_en); endproperty
  a_hold: assert property (p_hold) else $error("field changed unwritten");
endmodule : cpr_regs_assertions
bind cpr_regs cpr_regs_assertions u_chk (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .lo_rate, .preamp_fb_en, .stepped_attenuation_on, .stepped_attenuation_depth,
  .summer_power_on, .gain_stage_observe, .summer_fb_en);

// *** verif/cw_and_preamp_config_regs_tb_top.sv ***
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value %0t got %0h want %0h", $time, a, e); end end
module cw_and_preamp_config_regs_tb_top;
  import cpr_pkg::*;
  // ****
  // signals and expectation tables
  // ****
  logic                   clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0]      paddr = '0;
  logic [31:0]            pwdata = '0, prdata, mph, rnd = 32'h429e;
  logic                   pready, pslverr, pto, son, obs, aon, cwm;
  logic [2:0]             dep;
  logic [4:0]             pfb, sfb;
  logic [16:0]            x, q[$];
  cpr_lo_t                lo;
  cpr_gain_t [LANES-1:0]  lg;
  cpr_hp_t                hp;
  cpr_lo_t                lt[4] = '{CPR_LO_16X, CPR_LO_8X, CPR_LO_4X, CPR_LO_1X};
  cpr_gain_t              gt[4] = '{CPR_G18, CPR_G24, CPR_G12, CPR_GRSV};
  cpr_hp_t                ht[4] = '{CPR_HP100, CPR_HP50, CPR_HP200, CPR_HP150};
  int                     idx[6] = '{IDX_FB, IDX_SUM, IDX_PH14, IDX_PH58, IDX_GAIN, IDX_TEST};
  int                     num_errors = 0, n_tests = 0;
  cpr_regs dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .lo_rate(lo), .mixer_phase_per_lane(mph), .lane_gain(lg),
    .preamp_highpass_corner(hp), .preamp_fb_en(pfb), .preset_term_used(pto),
    .stepped_attenuation_on(aon), .stepped_attenuation_depth(dep), .summer_power_on(son),
    .gain_stage_observe(obs), .summer_fb_en(sfb), .continuous_wave_mode(cwm));
  // ****
  // bus tasks; the master never assumes the wait count
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic bus(input logic w, input int ix, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1;
    pwrite  <= w;
    paddr   <= ADDR_W'(4 * ix);
    pwdata  <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 0;
    penable <= 0;
    #1;
  endtask : bus
  task automatic rd(input int ix, input logic [16:0] e);
    q.push_back(e);
    bus(0, ix, 0);
  endtask : rd
  task automatic stop_test;
    // a read whose answer never came is a mismatch too
    if (q.size() != 0) num_errors++;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready && q.size() > 0) begin
      x = q.pop_front();
      `CHK({pslverr, prdata}, {x[16], 16'h0, x[15:0]})
    end
  end
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test;
  end
  // ****
  // main sequence
  // ****
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1;
    repeat (3) @(posedge clk);
    foreach (idx[i]) rd(idx[i], 0);
    `CHK(lg, {LANES{CPR_G18}})
    for (int c = 0; c < 4; c++) begin
      bus(1, IDX_TEST, c << 2);
      bus(1, IDX_SUM, c << 10);
      `CHK(lo, lt[c])
      `CHK(hp, ht[c])
      bus(1, IDX_TEST, (c << 2) | 32'h400);
      `CHK(lo, CPR_LO_32X)
    end
    repeat (8) begin
      rnd = lfsr(rnd);
      bus(1, IDX_PH14, rnd);
      bus(1, IDX_PH58, rnd >> 16);
      `CHK(mph, rnd)
      rd(IDX_PH58, rnd[31:16]);
      bus(1, IDX_FB, rnd | 32'h8000);
      bus(1, IDX_GAIN, rnd >> 8);
      `CHK(pfb, rnd[4:0])
      `CHK(pto, |rnd[7:6])
      for (int k = 0; k < LANES; k++) `CHK(lg[k], gt[rnd[8+2*k +: 2]])
      bus(1, IDX_FB, rnd & 32'h7fff);
      for (int k = 0; k < LANES; k++) `CHK(lg[k], gt[rnd[14:13]])
      bus(1, IDX_SUM, rnd | 32'h100);
      `CHK({cwm, pfb}, {1'b1, rnd[4:0]})
      `CHK(sfb, rnd[4:0])
      bus(1, IDX_TEST, rnd);
      `CHK(aon, rnd[7])
      `CHK(dep, rnd[7] ? rnd[6:4] : 3'h0)
      `CHK(obs, rnd[9])
      `CHK(son, !rnd[9] | rnd[8])
    end
    rd(0, 17'h10000);
    @(posedge clk);
    arst_n <= 0;
    @(posedge clk);
    arst_n <= 1;
    repeat (3) @(posedge clk);
    // unmapped write must be ignored, test word stays at its reset value
    bus(1, 0, 32'hffff);
    rd(IDX_TEST, 0);
    stop_test;
  end
endmodule : cw_and_preamp_config_regs_tb_top
